// ---- hw/srwc_top.v ----
// Contract
// - Raise the wrap output when the sequence reaches the final array address.
// - Sequential mode uses select, restart, finish and wrap-in dedicated inputs.
// - After wrap, a no-op cycle with all selects low clears wrap state.
// - The no-op may be four cycles, each with one different select low.
// - During clearing no-op cycles data stays high-Z, no read or write.
// - Sequence starts at address zero and advances on every rising edge; the code advances only on edges that carry a sequence cycle.
//
// Implementation choices: register access over AXI4-Lite and the register offsets.
`include "srwc_regs.vh"
`timescale 1ns/100ps
`default_nettype none

module srwc_top
#(
  parameter [20:0] LAST_ADDR = `SRWC_LAST_ADDR
)
(
  input wire sys_clk,
  input wire rst,
  input wire [3:0] dieSelN,
  input wire seqRdSel,
  input wire restartIn,
  input wire finishIn,
  input wire wrapIn,
  input wire writeStrobe,
  output reg wrapOut,
  output reg [15:0] dataOut,
  output reg dataOe,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_SEQ = 3'b010;
  localparam [2:0] ST_WRAP = 3'b100;

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  reg [8:0] pinMeta_q;
  reg [8:0] pinSync_q;

  always @(posedge sys_clk)
  begin
    pinMeta_q <= {writeStrobe, wrapIn, finishIn, restartIn, seqRdSel, dieSelN};
    pinSync_q <= pinMeta_q;
  end

  wire [3:0] selN = pinSync_q[3:0];
  wire seqS = pinSync_q[4];
  wire restartS = pinSync_q[5];
  wire finishS = pinSync_q[6];
  wire wrapInS = pinSync_q[7];
  wire weS = pinSync_q[8];

  function oneLow;
    input [3:0] sel;
    begin
      oneLow = (sel == 4'he) || (sel == 4'hd) || (sel == 4'hb) || (sel == 4'h7);
    end
  endfunction

  // --------------------------------------------------------------------------
  // Cycle decode
  // --------------------------------------------------------------------------
  reg [31:0] ctrl_q;
  wire allLow = (selN == 4'h0);
  wire seqCycle = allLow & seqS & ~weS & ctrl_q[`SRWC_CTRL_EN_BIT];
  wire nopAll = allLow & ~seqS;
  wire nopOne = oneLow(selN) & ~seqS;

  // --------------------------------------------------------------------------
  // Sequence state machine
  // --------------------------------------------------------------------------
  reg [2:0] state_q;
  reg [20:0] addr_q;
  reg [3:0] clrMask_q;
  reg issue_q;
  reg issueD1_q;
  wire [3:0] maskNext = clrMask_q | ~selN;
  wire [15:0] memRd;

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      addr_q <= `SRWC_START_ADDR;
      clrMask_q <= 4'h0;
      wrapOut <= 1'b0;
      issue_q <= 1'b0;
    end
    else
    begin
      issue_q <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          if (wrapInS)
          begin
            state_q <= ST_WRAP;
            wrapOut <= 1'b1;
          end
          else if (seqCycle)
          begin
            state_q <= ST_SEQ;
            addr_q <= `SRWC_START_ADDR + 21'h000001;
            issue_q <= 1'b1;
            clrMask_q <= 4'h0;
          end
        end
        ST_SEQ:
        begin
          if (wrapInS)
          begin
            state_q <= ST_WRAP;
            wrapOut <= 1'b1;
          end
          else if (finishS)
          begin
            state_q <= ST_IDLE;
            addr_q <= `SRWC_START_ADDR;
          end
          else if (seqCycle && restartS)
          begin
            addr_q <= `SRWC_START_ADDR + 21'h000001;
            issue_q <= 1'b1;
          end
          else if (seqCycle)
          begin
            issue_q <= 1'b1;
            if (addr_q == LAST_ADDR)
            begin
              state_q <= ST_WRAP;
              wrapOut <= 1'b1;
            end
            else
            begin
              addr_q <= addr_q + 21'h000001;
            end
          end
        end
        ST_WRAP:
        begin
          if (nopAll || (nopOne && (maskNext == 4'hf)))
          begin
            state_q <= ST_IDLE;
            wrapOut <= 1'b0;
            clrMask_q <= 4'h0;
            addr_q <= `SRWC_START_ADDR;
          end
          else if (nopOne)
          begin
            clrMask_q <= maskNext;
          end
        end
        default:
        begin
          state_q <= ST_IDLE;
          wrapOut <= 1'b0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Read data path: only issued sequence cycles drive the bus.
  // --------------------------------------------------------------------------
  // The memory is read one edge after the issue, when addr_q has already moved on.
  // Capturing the issued address here keeps the first word at address zero.
  reg [3:0] issueAddr_q;

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      issueAddr_q <= 4'h0;
    end
    else if (seqCycle)
    begin
      issueAddr_q <= (state_q == ST_SEQ && !restartS) ? addr_q[3:0] : 4'h0;
    end
  end

  wire winWrite;
  wire [3:0] winWrAddr;
  reg [31:0] wData_q;

  srwc_mem u_mem
  (
    .sys_clk(sys_clk),
    .wrEn(winWrite),
    .wrAddr(winWrAddr),
    .wrData(wData_q[15:0]),
    .rdAddr(issueAddr_q),
    .rdData(memRd)
  );

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      issueD1_q <= 1'b0;
      dataOe <= 1'b0;
      dataOut <= 16'h0000;
    end
    else
    begin
      issueD1_q <= issue_q;
      dataOe <= issueD1_q & ~nopAll & ~nopOne;
      dataOut <= (issueD1_q & ~nopAll & ~nopOne) ? memRd : 16'h0000;
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite slave
  // --------------------------------------------------------------------------
  reg [7:0] awAddr_q;
  reg awHave_q;
  reg [3:0] wStrb_q;
  reg wHave_q;
  wire doWrite = awHave_q & wHave_q & ~s_axi_bvalid;
  wire awIsWin = (awAddr_q >= `SRWC_OFF_WIN_BASE) && (awAddr_q <= `SRWC_OFF_WIN_LAST);
  assign winWrite = doWrite & awIsWin & (&wStrb_q[1:0]);
  assign winWrAddr = awAddr_q[5:2];

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SRWC_RESP_OKAY;
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
      ctrl_q <= `SRWC_CTRL_RESET;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awAddr_q <= s_axi_awaddr;
        awHave_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
        wHave_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (doWrite)
      begin
        awHave_q <= 1'b0;
        wHave_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `SRWC_RESP_OKAY;
        if (awAddr_q == `SRWC_OFF_CTRL)
        begin
          if (wStrb_q[0])
          begin
            ctrl_q[`SRWC_CTRL_EN_BIT] <= wData_q[`SRWC_CTRL_EN_BIT];
          end
        end
        else if (!awIsWin && awAddr_q != `SRWC_OFF_STATUS && awAddr_q != `SRWC_OFF_ADDR)
        begin
          s_axi_bresp <= `SRWC_RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SRWC_RESP_OKAY;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `SRWC_RESP_OKAY;
        s_axi_rdata <= 32'h00000000;
        if (s_axi_araddr == `SRWC_OFF_CTRL)
        begin
          s_axi_rdata <= ctrl_q;
        end
        else if (s_axi_araddr == `SRWC_OFF_STATUS)
        begin
          s_axi_rdata <= {24'h000000, clrMask_q, 2'b00, (state_q == ST_SEQ), wrapOut};
        end
        else if (s_axi_araddr == `SRWC_OFF_ADDR)
        begin
          s_axi_rdata <= {11'h000, addr_q};
        end
        else if (s_axi_araddr < `SRWC_OFF_WIN_BASE || s_axi_araddr > `SRWC_OFF_WIN_LAST)
        begin
          s_axi_rresp <= `SRWC_RESP_SLVERR;
        end
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ---- pkg/srwc_regs.vh ----
`ifndef SRWC_REGS_VH
`define SRWC_REGS_VH

// ----------------------------------------------------------------------------
// Register map (byte addresses on the AXI4-Lite bus)
// ----------------------------------------------------------------------------
`define SRWC_OFF_CTRL 8'h00
`define SRWC_OFF_STATUS 8'h04
`define SRWC_OFF_ADDR 8'h08
`define SRWC_OFF_WIN_BASE 8'h40
`define SRWC_OFF_WIN_LAST 8'h7c

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define SRWC_CTRL_EN_BIT 0
`define SRWC_CTRL_RESET 32'h00000001
`define SRWC_STAT_WRAP_BIT 0
`define SRWC_STAT_SEQ_BIT 1
`define SRWC_STAT_MASK_LSB 4
`define SRWC_STAT_MASK_MSB 7

// ----------------------------------------------------------------------------
// Array geometry and sequence limits
// ----------------------------------------------------------------------------
`define SRWC_ADDR_W 21
`define SRWC_LAST_ADDR 21'h1fffff
`define SRWC_START_ADDR 21'h000000
`define SRWC_DATA_W 16
`define SRWC_WIN_AW 4
`define SRWC_WIN_DEPTH 16
`define SRWC_DIES 4

// ----------------------------------------------------------------------------
// AXI4-Lite response codes
// ----------------------------------------------------------------------------
`define SRWC_RESP_OKAY 2'b00
`define SRWC_RESP_SLVERR 2'b10

`endif

// ---- hw/srwc_mem.v ----
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------------
// Data window: one write port from software, registered read port.
// ----------------------------------------------------------------------------
module srwc_mem
(
  input wire sys_clk,
  input wire wrEn,
  input wire [3:0] wrAddr,
  input wire [15:0] wrData,
  input wire [3:0] rdAddr,
  output reg [15:0] rdData
);

  reg [15:0] store [0:15];

  always @(posedge sys_clk)
  begin
    if (wrEn)
    begin
      store[wrAddr] <= wrData;
    end
    rdData <= store[rdAddr];
  end

endmodule

`default_nettype wire

// ---- verification/srwc_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------------
// Pin and bus checks for the wrap control block.
// ----------------------------------------------------------------------------
module srwc_checker
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] dieSelN,
  input wire logic seqRdSel,
  input wire logic writeStrobe,
  input wire logic wrapIn,
  input wire logic wrapOut,
  input wire logic [15:0] dataOut,
  input wire logic dataOe,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [5:0] seqHist;
  logic [5:0] wrapHist;
  logic [2:0] noopAge;
  wire seqPin = dieSelN == 4'h0 && seqRdSel && !writeStrobe;
  wire noopPin = !seqRdSel && (dieSelN == 4'h0 || $onehot(~dieSelN));
  // Pin history absorbs the synchroniser lag.
  always @(posedge sys_clk)
  begin
    seqHist <= {seqHist[4:0], seqPin};
    wrapHist <= {wrapHist[4:0], wrapIn};
    noopAge <= rst ? 3'h7 : noopPin ? 3'h0 : noopAge == 3'h7 ? noopAge : noopAge + 3'h1;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_wrap_cause: assert property ($rose(wrapOut) |-> |{seqHist, wrapHist})
    else $error("wrap rose without a sequence cycle");
  a_wrap_holds: assert property ($fell(wrapOut) |-> noopAge < 3'h6)
    else $error("wrap cleared without a no-op");
  a_oe_cause: assert property (dataOe |-> |seqHist[5:2])
    else $error("data driven without a sequence cycle");
  a_wrap_quiet: assert property (wrapOut && $past(wrapOut, 3) |-> !dataOe)
    else $error("data driven in wrap state");
  a_data_zero: assert property (!dataOe |-> dataOut == 16'h0000)
    else $error("data not zero while released");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken during response");
  cover property ($rose(wrapOut));
  cover property ($fell(wrapOut));
  cover property (dataOe);
endmodule
`default_nettype wire

// ---- verification/srwc_ctl_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------------
// Controller model: 0 idle, 1 sequence, 2 full no-op, 3 to 6 single no-op.
// ----------------------------------------------------------------------------
module srwc_ctl_model
(
  input wire logic sys_clk,
  input wire logic [2:0] mode,
  output var logic [3:0] dieSelN = 4'hf,
  output var logic seqRdSel = 1'h0,
  output var logic writeStrobe = 1'h0
);
  always @(posedge sys_clk)
  begin
    seqRdSel <= mode == 3'h1;
    writeStrobe <= 1'h0;
    dieSelN <= mode == 3'h0 ? 4'hf : mode < 3'h3 ? 4'h0 : ~(4'h1 << (mode - 3'h3));
  end
endmodule
`default_nettype wire

// ---- verification/tb_sequential_read_wrap_control.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
// ----------------------------------------------------------------------------
// Bench for the wrap control block.
// ----------------------------------------------------------------------------
module tb_sequential_read_wrap_control;
  localparam logic [20:0] LAST = 21'h000007;
  logic sys_clk = 1'h0;
  logic rst = 1'h1;
  logic [2:0] mode = 3'h0;
  logic finishIn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [3:0] dieSelN;
  logic seqRdSel, writeStrobe, wrapOut, dataOe, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [15:0] dataOut;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [31:0] s_axi_rdata, rd;
  int failures = 0;
  int check_count = 0;
  logic [15:0] seed = 16'h0028;
  logic [15:0] win [8];
  logic [15:0] got [$];
  srwc_top #(.LAST_ADDR(LAST)) u_srwc_top (.sys_clk, .rst, .dieSelN, .seqRdSel,
    .restartIn(1'h0), .finishIn, .wrapIn(1'h0), .writeStrobe, .wrapOut, .dataOut, .dataOe,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  srwc_ctl_model u_srwc_ctl_model (.sys_clk, .mode, .dieSelN, .seqRdSel, .writeStrobe);
  initial forever #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (dataOe === 1'h1) got.push_back(dataOut);
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h1;
    @(posedge sys_clk);
    s_axi_bready <= 1'h0;
    `CHK(s_axi_bresp, 2'h0)
  endtask
  task automatic axr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h1;
    @(posedge sys_clk);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic step(input logic [2:0] m, input int n);
    mode <= m;
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic give_verdict;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    give_verdict();
  end
  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'h0;
    repeat (3) @(posedge sys_clk);
    `CHK({wrapOut, dataOe}, 2'h0)
    axr(8'h00);
    `CHK({rr, rd}, 34'h000000001)
    axr(8'h20);
    `CHK(rr, 2'h2)
    for (int i = 0; i < 8; i++)
    begin
      seed = lfsr(seed);
      win[i] = seed;
      axw(8'h40 + 8'(4 * i), {16'h0, seed});
    end
    for (int r = 0; r < 2; r++)
    begin
      got.delete();
      mode <= 3'h1;
      for (int n = 0; n < 200 && wrapOut !== 1'h1; n++) @(posedge sys_clk);
      step(3'h1, 4);
      step(3'h0, 10);
      `CHK(got.size(), 8)
      foreach (got[i]) `CHK(got[i], win[i])
      `CHK(wrapOut, 1'h1)
      if (r == 0)
        step(3'h2, 1);
      else
      begin
        step(3'h3, 1);
        step(3'h0, 2);
        step(3'h5, 1);
        step(3'h4, 1);
        step(3'h0, 6);
        `CHK(wrapOut, 1'h1)
        step(3'h6, 1);
      end
      step(3'h0, 6);
      `CHK(wrapOut, 1'h0)
      finishIn <= 1'h1;
      repeat (3) @(posedge sys_clk);
      finishIn <= 1'h0;
      repeat (3) @(posedge sys_clk);
    end
    give_verdict();
  end
endmodule
bind srwc_top srwc_checker u_srwc_checker (.sys_clk, .rst, .dieSelN, .seqRdSel, .writeStrobe,
  .wrapIn, .wrapOut, .dataOut, .dataOe, .s_axi_awready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire
